/* File: fns_host_model.sv */
// serial control host model for the synthesiser control port
`timescale 1ns/1ns
module fns_host_model (
    output logic ser_clk,
    output logic ser_cs_n,
    output logic ser_data_in,
    input wire ser_data_out,
    input wire ser_data_oe
);
    logic last_q = 1'b0;
    wire sd_line = ser_data_oe ? ser_data_out : ~last_q;
    initial begin
        ser_clk = 1'b0;
        ser_cs_n = 1'b1;
        ser_data_in = 1'b0;
    end
    always @(posedge ser_clk) begin
        last_q <= sd_line;
    end
    // one frame of 8 address and 16 data bits, msb first; clock idles low between frames
    task automatic frame(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
        logic [23:0] w;
        w = {a, d};
        q = 16'h0000;
        ser_cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            ser_data_in = w[i];
            #62 ser_clk = 1'b1;
            if (i < 16) q[i] = sd_line;
            #63 ser_clk = 1'b0;
        end
        #63 ser_cs_n = 1'b1;
        ser_data_in = ~ser_data_in;
        #100;
    endtask
endmodule // fns_host_model

/* File: fns_regs.vh */
// register map, field positions, reset values and timing counts of the synthesiser control
`ifndef FNS_REGS_VH
`define FNS_REGS_VH
`define FNS_ADDR_W 8
`define FNS_DATA_W 16
`define FNS_FRAME_BITS 5'h18
`define FNS_A_GENERAL_RESET 8'h01
`define FNS_A_GENERAL_CONTROL 8'h31
`define FNS_A_SYNTH_CONFIG 8'h34
`define FNS_A_BLEED_CURRENT_CONFIG 8'h35
`define FNS_A_LOCK_DETECT_CONFIG 8'h36
`define FNS_A_FAST_LOCK_CONFIG 8'h37
`define FNS_A_REFERENCE_DIVIDER 8'h38
`define FNS_A_INTEGER_DIVIDER 8'h39
`define FNS_A_FRACTION_LOW 8'h3a
`define FNS_A_FRACTION_HIGH 8'h3b
`define FNS_A_OUTPUT_PATH_CONTROL 8'h3f
`define FNS_A_GENERAL_CONTROL_READBACK 8'hc1
`define FNS_A_DEVICE_STATUS 8'hc4
`define FNS_A_INTERRUPT_ENABLE 8'hc5
`define FNS_A_POWER_STATUS 8'hc6
`define FNS_A_REFERENCE_DIVIDER_READBACK 8'hc8
`define FNS_A_INTEGER_DIVIDER_READBACK 8'hc9
`define FNS_A_FRACTION_LOW_READBACK 8'hca
`define FNS_A_FRACTION_HIGH_READBACK 8'hcb
`define FNS_A_OUTPUT_PATH_READBACK 8'hcf
`define FNS_A_INTERRUPT_ENABLE_WR 8'h45
`define FNS_READ_BIT 7
`define FNS_RST_REG 16'h0000
`define FNS_GC_REF_AMP_EN 0
`define FNS_GC_IF_EN 1
`define FNS_GC_RF_EN 2
`define FNS_SC_MODE_HI 14
`define FNS_SC_MODE_LO 11
`define FNS_SC_MODE_INTEGER 4'h0
`define FNS_SC_RES16 9
`define FNS_LD_DIGITAL 0
`define FNS_LD_COUNT_HI 11
`define FNS_LD_COUNT_LO 4
`define FNS_LD_FAST_LOCK_EN 12
`define FNS_DS_LOCK 0
`define FNS_DS_FAST_LOCK 1
`define FNS_DS_CP_ON 2
`define FNS_DS_REF_CLK_OK 7
`define FNS_CLK_PERIOD_NS 8
`define FNS_CLK_STABLE_NS 1000
`define FNS_CLK_STABLE_CYC ((`FNS_CLK_STABLE_NS + `FNS_CLK_PERIOD_NS - 1) / `FNS_CLK_PERIOD_NS)
`endif

/* File: fns_synth_checker.sv */
// assertions on the synthesiser control ports
`timescale 1ns/1ns
module fns_synth_checker (
    input wire ref_clk,
    input wire rst,
    input wire reset_in_low,
    input wire ser_cs_n,
    input wire ser_data_oe,
    input wire ref_amp_en,
    input wire ref_clk_gate,
    input wire synth_pwr,
    input wire if_synth_pwr,
    input wire cp_enable,
    input wire fast_lock_output,
    input wire lock_detect,
    input wire [15:0] div_int,
    input wire [23:0] div_frac,
    input wire div_load
);
    logic [7:0] amp_cnt_q;
    logic [7:0] amp_cnt_d;
    // cycles the reference amplifier has been on
    assign amp_cnt_d = (rst || !ref_amp_en) ? 8'h00 : (amp_cnt_q == 8'hff) ? amp_cnt_q : amp_cnt_q + 8'h01;
    always @(posedge ref_clk) begin
        amp_cnt_q <= amp_cnt_d;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst || !reset_in_low);
    sequence s_cs_idle;
        ser_cs_n [*6];
    endsequence
    sequence s_apply;
        div_load ##1 !div_load;
    endsequence
    AST_RESET_CLEARS: assert property (disable iff (!reset_in_low)
        rst |=> !(cp_enable || fast_lock_output || div_load || synth_pwr || ref_amp_en || ser_data_oe))
        else $error("outputs not cleared by reset");
    AST_AMP_ON: assert property ((synth_pwr || if_synth_pwr) |-> ref_amp_en)
        else $error("amplifier off while a synthesiser is on");
    AST_GATE_HOLD: assert property ($rose(ref_clk_gate) |-> amp_cnt_q >= 8'd124)
        else $error("clock released before stable time");
    AST_CP_ON_LOAD: assert property ($rose(cp_enable) |-> div_load)
        else $error("charge pump enabled without divider load");
    AST_FL_ON_LOAD: assert property ($rose(fast_lock_output) |-> div_load)
        else $error("fast lock started without divider load");
    AST_LOAD_PULSE: assert property (div_load |-> s_apply)
        else $error("load pulse longer than one cycle");
    AST_RATIO_HOLD: assert property (!div_load |-> $stable(div_int) && $stable(div_frac))
        else $error("ratio changed without load pulse");
    AST_LOCK_NEEDS_CP: assert property (lock_detect |-> cp_enable || $past(cp_enable))
        else $error("lock shown with charge pump off");
    AST_LOAD_IN_FRAME: assert property (div_load |-> $past(ser_cs_n, 3) == 1'b0)
        else $error("load pulse outside a frame");
    AST_OE_RELEASE: assert property (s_cs_idle |-> !ser_data_oe)
        else $error("data output driven while deselected");
endmodule // fns_synth_checker

/* File: fns_synth_control.v */
// digital control of the fractional-n synthesiser behind its serial control port
// Contract
// [RULE1] power-up equals general reset state
// [RULE2] reset pin gives same general reset state
// [RULE3] power status shows each regulator stable
// [RULE4] reference amplifier on when either synthesiser enabled
// [RULE5] gate reference clock until stable, whole cycles
// [RULE6] device status bit 7 reports reference clock
// [RULE7] fraction has 24-bit resolution
// [RULE8] divider update switches to fast-lock setting
// [RULE9] fast lock ends by itself after delay
// [RULE10] lock detector selectable analogue or digital
// [RULE11] general control bit 2 enables synthesiser
// [RULE12] charge pump off until first divider load
// [RULE13] host writes setup registers before divider
// [RULE14] loop runs once divider loaded, rewritable
// [RULE15] host keeps fixed divider write order
// [RULE16] integer mode applies on integer write
// [RULE17] fractional modes apply on lower fraction write
// [RULE18] fast-lock enable bit 12 triggers per apply
`timescale 1ns/1ns
`include "fns_regs.vh"
module fns_synth_control (
    input wire ref_clk,
    input wire rst,
    input wire ce,
    input wire reset_in_low,
    input wire ser_clk,
    input wire ser_cs_n,
    input wire ser_data_in,
    output reg ser_data_out,
    output reg ser_data_oe,
    input wire [3:0] reg_stable,
    input wire lock_analog,
    input wire phase_ok,
    output reg ref_amp_en,
    output reg ref_clk_gate,
    output reg synth_pwr,
    output reg if_synth_pwr,
    output reg cp_enable,
    output reg fast_lock_output,
    output reg lock_detect,
    output reg [15:0] synth_config_out,
    output reg [15:0] bleed_out,
    output reg [15:0] out_path_out,
    output reg [15:0] ref_div_out,
    output reg [15:0] div_int,
    output reg [23:0] div_frac,
    output reg div_load
);
    // synchronisers: first stage read only by second
    reg [4:0] sclk_s_q;
    reg [2:0] cs_s_q;
    reg [1:0] din_s_q;
    reg [1:0] rstn_s_q;
    reg [3:0] pwr_s1_q;
    reg [3:0] pwr_s2_q;
    reg [1:0] lka_s_q;
    reg [1:0] pok_s_q;
    // serial port
    reg [4:0] bit_cnt_q;
    reg [7:0] addr_q;
    reg [15:0] shin_q;
    reg [15:0] shout_q;
    reg rd_act_q;
    reg cmd_rst_q;
    // registers
    reg [15:0] general_control_q;
    reg [15:0] synth_config_q;
    reg [15:0] bleed_current_config_q;
    reg [15:0] lock_detect_config_q;
    reg [15:0] fast_lock_config_q;
    reg [15:0] reference_divider_q;
    reg [15:0] integer_divider_q;
    reg [15:0] fraction_low_q;
    reg [15:0] fraction_high_q;
    reg [15:0] output_path_control_q;
    reg [15:0] interrupt_enable_q;
    // control state
    reg [7:0] stab_cnt_q;
    reg clk_ok_q;
    reg [15:0] fl_cnt_q;
    reg [7:0] lk_cnt_q;

    wire sclk_rise = sclk_s_q[3] & ~sclk_s_q[4];
    wire sclk_fall = ~sclk_s_q[3] & sclk_s_q[4];
    wire cs_act = ~cs_s_q[1];
    wire pin_rst = ~rstn_s_q[1];
    wire gen_rst = rst | pin_rst | cmd_rst_q; // [RULE1] [RULE2]
    wire rf_en = general_control_q[`FNS_GC_RF_EN];
    wire if_en = general_control_q[`FNS_GC_IF_EN];
    wire amp_want = general_control_q[`FNS_GC_REF_AMP_EN] | rf_en | if_en; // [RULE4]
    wire wr_done = cs_act & sclk_rise & (bit_cnt_q == 5'h17) & ~addr_q[`FNS_READ_BIT];
    wire [15:0] wr_data = {shin_q[14:0], din_s_q[1]};

    // true when the synthesiser configuration selects a fractional modulator
    function frac_mode;
        input [15:0] cfg;
        begin
            frac_mode = (cfg[`FNS_SC_MODE_HI:`FNS_SC_MODE_LO] != `FNS_SC_MODE_INTEGER);
        end
    endfunction

    // register value returned for a read address
    function [15:0] read_mux;
        input [7:0] a;
        input [15:0] ds;
        begin
            case (a)
                `FNS_A_GENERAL_CONTROL_READBACK: read_mux = general_control_q;
                `FNS_A_DEVICE_STATUS: read_mux = ds;
                `FNS_A_INTERRUPT_ENABLE: read_mux = interrupt_enable_q;
                `FNS_A_POWER_STATUS: read_mux = {12'h000, pwr_s2_q}; // [RULE3]
                `FNS_A_REFERENCE_DIVIDER_READBACK: read_mux = reference_divider_q;
                `FNS_A_INTEGER_DIVIDER_READBACK: read_mux = integer_divider_q;
                `FNS_A_FRACTION_LOW_READBACK: read_mux = fraction_low_q;
                `FNS_A_FRACTION_HIGH_READBACK: read_mux = fraction_high_q;
                `FNS_A_OUTPUT_PATH_READBACK: read_mux = output_path_control_q;
                default: read_mux = 16'h0000;
            endcase
        end
    endfunction

    wire [15:0] dev_status = {8'h00, clk_ok_q, 4'h0, cp_enable, fast_lock_output, lock_detect}; // [RULE6]
    wire [7:0] cur_addr = {addr_q[6:0], din_s_q[1]};

    // divide ratio takes effect: integer write in integer mode, low fraction write otherwise
    wire apply_int = wr_done & (addr_q == `FNS_A_INTEGER_DIVIDER) & ~frac_mode(synth_config_q); // [RULE16]
    wire apply_frac = wr_done & (addr_q == `FNS_A_FRACTION_LOW) & frac_mode(synth_config_q); // [RULE17]
    wire apply = apply_int | apply_frac;

    // synchronisers, reset only by the power-on reset
    always @(posedge ref_clk) begin
        if (rst) begin
            sclk_s_q <= 5'h00;
            cs_s_q <= 3'h7;
            din_s_q <= 2'h0;
            rstn_s_q <= 2'h3;
            pwr_s1_q <= 4'h0;
            pwr_s2_q <= 4'h0;
            lka_s_q <= 2'h0;
            pok_s_q <= 2'h0;
        end else if (ce) begin
            sclk_s_q <= {sclk_s_q[3:0], ser_clk};
            cs_s_q <= {cs_s_q[1:0], ser_cs_n};
            din_s_q <= {din_s_q[0], ser_data_in};
            rstn_s_q <= {rstn_s_q[0], reset_in_low};
            pwr_s1_q <= reg_stable;
            pwr_s2_q <= pwr_s1_q; // [RULE3]
            lka_s_q <= {lka_s_q[0], lock_analog};
            pok_s_q <= {pok_s_q[0], phase_ok};
        end
    end

    // serial frame: 8 address bits then 16 data bits, msb first, sampled on rising clock
    always @(posedge ref_clk) begin
        if (rst | pin_rst) begin
            bit_cnt_q <= 5'h00;
            addr_q <= 8'h00;
            shin_q <= 16'h0000;
            shout_q <= 16'h0000;
            rd_act_q <= 1'b0;
            cmd_rst_q <= 1'b0;
            ser_data_out <= 1'b0;
            ser_data_oe <= 1'b0;
        end else if (ce) begin
            cmd_rst_q <= 1'b0;
            if (!cs_act) begin
                bit_cnt_q <= 5'h00;
                rd_act_q <= 1'b0;
                ser_data_oe <= 1'b0;
                ser_data_out <= 1'b0;
            end else begin
                if (sclk_rise && bit_cnt_q != `FNS_FRAME_BITS) begin
                    bit_cnt_q <= bit_cnt_q + 5'h01;
                    if (bit_cnt_q < 5'h08) begin
                        addr_q <= cur_addr;
                    end else begin
                        shin_q <= wr_data;
                    end
                    if (bit_cnt_q == 5'h07) begin
                        if (cur_addr == `FNS_A_GENERAL_RESET) begin
                            cmd_rst_q <= 1'b1; // [RULE1]
                        end
                        if (cur_addr[`FNS_READ_BIT]) begin
                            rd_act_q <= 1'b1;
                            shout_q <= read_mux(cur_addr, dev_status);
                        end
                    end
                end
                if (sclk_fall && rd_act_q) begin
                    ser_data_oe <= 1'b1;
                    ser_data_out <= shout_q[15];
                    shout_q <= {shout_q[14:0], 1'b0};
                end
            end
        end
    end

    // control registers, all cleared by any general reset source
    always @(posedge ref_clk) begin
        if (gen_rst) begin // [RULE1] [RULE2]
            general_control_q <= `FNS_RST_REG;
            synth_config_q <= `FNS_RST_REG;
            bleed_current_config_q <= `FNS_RST_REG;
            lock_detect_config_q <= `FNS_RST_REG;
            fast_lock_config_q <= `FNS_RST_REG;
            reference_divider_q <= `FNS_RST_REG;
            integer_divider_q <= `FNS_RST_REG;
            fraction_low_q <= `FNS_RST_REG;
            fraction_high_q <= `FNS_RST_REG;
            output_path_control_q <= `FNS_RST_REG;
            interrupt_enable_q <= `FNS_RST_REG;
        end else if (ce && wr_done) begin
            case (addr_q)
                `FNS_A_GENERAL_CONTROL: general_control_q <= wr_data; // [RULE11]
                `FNS_A_SYNTH_CONFIG: synth_config_q <= wr_data;
                `FNS_A_BLEED_CURRENT_CONFIG: bleed_current_config_q <= wr_data;
                `FNS_A_LOCK_DETECT_CONFIG: lock_detect_config_q <= wr_data;
                `FNS_A_FAST_LOCK_CONFIG: fast_lock_config_q <= wr_data;
                `FNS_A_REFERENCE_DIVIDER: reference_divider_q <= wr_data;
                `FNS_A_INTEGER_DIVIDER: integer_divider_q <= wr_data;
                `FNS_A_FRACTION_LOW: fraction_low_q <= wr_data;
                `FNS_A_FRACTION_HIGH: fraction_high_q <= wr_data;
                `FNS_A_OUTPUT_PATH_CONTROL: output_path_control_q <= wr_data;
                `FNS_A_INTERRUPT_ENABLE_WR: interrupt_enable_q <= wr_data;
                default: general_control_q <= general_control_q;
            endcase
        end
    end

    // reference amplifier, stability hold-off and clock gate
    always @(posedge ref_clk) begin
        if (gen_rst) begin
            ref_amp_en <= 1'b0;
            stab_cnt_q <= 8'h00;
            clk_ok_q <= 1'b0;
            ref_clk_gate <= 1'b0;
            synth_pwr <= 1'b0;
            if_synth_pwr <= 1'b0;
        end else if (ce) begin
            ref_amp_en <= amp_want; // [RULE4] [RULE11]
            synth_pwr <= rf_en; // [RULE11]
            if_synth_pwr <= if_en;
            if (!ref_amp_en) begin
                stab_cnt_q <= 8'h00;
                clk_ok_q <= 1'b0;
            end else if (stab_cnt_q == `FNS_CLK_STABLE_CYC - 1) begin
                clk_ok_q <= 1'b1; // [RULE5]
            end else begin
                stab_cnt_q <= stab_cnt_q + 8'h01;
            end
            // gate changes only on a rising edge so the first passed cycle is whole
            ref_clk_gate <= clk_ok_q & ref_amp_en; // [RULE5]
        end
    end

    // main divider, charge pump release and fast lock
    always @(posedge ref_clk) begin
        if (gen_rst) begin
            div_int <= 16'h0000;
            div_frac <= 24'h000000;
            div_load <= 1'b0;
            cp_enable <= 1'b0;
            fast_lock_output <= 1'b0;
            fl_cnt_q <= 16'h0000;
        end else if (ce) begin
            div_load <= apply; // [RULE14]
            if (apply_int) begin
                div_int <= wr_data; // [RULE16]
                div_frac <= 24'h000000;
            end
            if (apply_frac) begin
                div_int <= integer_divider_q; // [RULE17]
                if (synth_config_q[`FNS_SC_RES16]) begin
                    div_frac <= {wr_data, 8'h00};
                end else begin
                    div_frac <= {fraction_high_q[7:0], wr_data}; // [RULE7]
                end
            end
            if (!rf_en) begin
                cp_enable <= 1'b0; // [RULE12]
            end else if (apply) begin
                cp_enable <= 1'b1; // [RULE12] [RULE14]
            end
            if (apply && lock_detect_config_q[`FNS_LD_FAST_LOCK_EN]) begin
                fast_lock_output <= 1'b1; // [RULE8] [RULE18]
                fl_cnt_q <= (fast_lock_config_q == 16'h0000) ? 16'h0001 : fast_lock_config_q;
            end else if (fast_lock_output) begin
                if (fl_cnt_q == 16'h0001) begin
                    fast_lock_output <= 1'b0; // [RULE9]
                end
                fl_cnt_q <= fl_cnt_q - 16'h0001;
            end
        end
    end

    // lock detector: analogue input or digital count of consecutive in-phase cycles
    always @(posedge ref_clk) begin
        if (gen_rst) begin
            lk_cnt_q <= 8'h00;
            lock_detect <= 1'b0;
        end else if (ce) begin
            if (!cp_enable) begin
                lk_cnt_q <= 8'h00;
                lock_detect <= 1'b0;
            end else if (!lock_detect_config_q[`FNS_LD_DIGITAL]) begin
                lk_cnt_q <= 8'h00;
                lock_detect <= lka_s_q[1]; // [RULE10]
            end else if (!pok_s_q[1]) begin
                lk_cnt_q <= 8'h00;
                lock_detect <= 1'b0;
            end else if (lk_cnt_q >= lock_detect_config_q[`FNS_LD_COUNT_HI:`FNS_LD_COUNT_LO]) begin
                lock_detect <= 1'b1; // [RULE10]
            end else begin
                lk_cnt_q <= lk_cnt_q + 8'h01;
            end
        end
    end

    // configuration fields handed to the analogue section
    always @(posedge ref_clk) begin
        if (gen_rst) begin
            synth_config_out <= 16'h0000;
            bleed_out <= 16'h0000;
            out_path_out <= 16'h0000;
            ref_div_out <= 16'h0000;
        end else if (ce) begin
            synth_config_out <= synth_config_q;
            bleed_out <= bleed_current_config_q;
            out_path_out <= output_path_control_q;
            ref_div_out <= reference_divider_q;
        end
    end
endmodule // fns_synth_control

/* File: tb_fns_synth_control.sv */
// self-checking bench for the synthesiser control
`timescale 1ns/1ns
module tb_fns_synth_control;
    logic ref_clk = 1'b0;
    logic rst, ce, reset_in_low, lock_analog, phase_ok;
    logic [3:0] reg_stable;
    wire ser_clk, ser_cs_n, ser_data_in, ser_data_out, ser_data_oe, ref_amp_en, ref_clk_gate;
    wire synth_pwr, if_synth_pwr, cp_enable, fast_lock_output, lock_detect, div_load;
    wire [15:0] synth_config_out, div_int, bleed_out, out_path_out, ref_div_out;
    wire [23:0] div_frac;
    int errors = 0;
    int checked = 0;
    int loads = 0;
    int fl_cyc = 0;
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (div_load === 1'b1) loads <= loads + 1;
        if (fast_lock_output === 1'b1) fl_cyc <= fl_cyc + 1;
    end
    fns_synth_control fns_synth_control_i (.ref_clk(ref_clk), .rst(rst), .ce(ce), .reset_in_low(reset_in_low),
        .ser_clk(ser_clk), .ser_cs_n(ser_cs_n), .ser_data_in(ser_data_in), .ser_data_out(ser_data_out),
        .ser_data_oe(ser_data_oe), .reg_stable(reg_stable), .lock_analog(lock_analog), .phase_ok(phase_ok),
        .ref_amp_en(ref_amp_en), .ref_clk_gate(ref_clk_gate), .synth_pwr(synth_pwr), .if_synth_pwr(if_synth_pwr),
        .cp_enable(cp_enable), .fast_lock_output(fast_lock_output), .lock_detect(lock_detect),
        .synth_config_out(synth_config_out), .bleed_out(bleed_out), .out_path_out(out_path_out),
        .ref_div_out(ref_div_out), .div_int(div_int),
        .div_frac(div_frac), .div_load(div_load));
    fns_host_model fns_host_model_i (.ser_clk(ser_clk), .ser_cs_n(ser_cs_n), .ser_data_in(ser_data_in),
        .ser_data_out(ser_data_out), .ser_data_oe(ser_data_oe));
    task automatic close_out;
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        fns_host_model_i.frame(a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        fns_host_model_i.frame(a, 16'h0000, q);
    endtask
    task automatic t_reset;
        logic [15:0] q;
        chk(24'({cp_enable, fast_lock_output, synth_pwr, ref_amp_en, div_load}), 24'h0);
        rd(8'hc6, q);
        chk(24'(q), 24'h0005);
        rd(8'h90, q);
        chk(24'(q), 24'h0);
    endtask
    task automatic t_enable;
        logic [15:0] q;
        int n;
        wr(8'h31, 16'h0002);
        chk(24'({if_synth_pwr, ref_amp_en, ref_clk_gate}), 24'h6);
        n = 0;
        while (ref_clk_gate !== 1'b1 && n < 300) begin
            step(1);
            n++;
        end
        if (n == 300) begin
            errors++;
            close_out;
        end
        rd(8'hc4, q);
        chk(24'(q[7]), 24'h1);
        wr(8'h31, 16'h0004);
        chk(24'({synth_pwr, ref_amp_en, if_synth_pwr, cp_enable}), 24'hc);
    endtask
    task automatic t_gen_reset;
        logic [15:0] q;
        wr(8'h34, 16'h6800);
        chk(24'(synth_config_out), 24'h6800);
        wr(8'h01, 16'h0000);
        chk(24'({synth_config_out, synth_pwr, ref_amp_en}), 24'h0);
        wr(8'h31, 16'h0004);
        rd(8'hc1, q);
        chk(24'(q), 24'h0004);
        wr(8'h45, 16'h0077);
        rd(8'hc5, q);
        chk(24'(q), 24'h0077);
    endtask
    task automatic t_integer;
        logic [15:0] q;
        int n;
        int f;
        wr(8'h34, 16'h0000);
        wr(8'h36, 16'h1000);
        wr(8'h37, 16'h0010);
        wr(8'h38, 16'h0001);
        chk(24'(ref_div_out), 24'h0001);
        wr(8'h35, 16'h0123);
        chk(24'(bleed_out), 24'h0123);
        wr(8'h3f, 16'h0456);
        chk(24'(out_path_out), 24'h0456);
        rd(8'hcf, q);
        chk(24'(q), 24'h0456);
        n = loads;
        f = fl_cyc;
        wr(8'h39, 16'h00b8);
        step(30);
        chk(24'(loads - n), 24'h1);
        chk({div_int, 7'h0, cp_enable}, 24'h00b801);
        chk(24'(fl_cyc - f), 24'h10);
        rd(8'hc9, q);
        chk(24'(q), 24'h00b8);
    endtask
    task automatic t_fraction;
        logic [15:0] q;
        int n;
        wr(8'h34, 16'h6800);
        n = loads;
        wr(8'h39, 16'h00b8);
        wr(8'h3b, 16'h0098);
        chk(24'(loads - n), 24'h0);
        wr(8'h3a, 16'haaab);
        chk(24'(loads - n), 24'h1);
        chk(div_frac, 24'h98aaab);
        rd(8'hcb, q);
        chk(24'(q), 24'h0098);
        rd(8'hca, q);
        chk(24'(q), 24'haaab);
        wr(8'h34, 16'h6a00);
        wr(8'h3a, 16'h1234);
        chk(div_frac, 24'h123400);
    endtask
    task automatic t_lock;
        lock_analog = 1'b1;
        step(10);
        chk(24'(lock_detect), 24'h1);
        wr(8'h36, 16'h1031);
        chk(24'(lock_detect), 24'h0);
        phase_ok = 1'b1;
        step(2);
        chk(24'(lock_detect), 24'h0);
        step(10);
        chk(24'(lock_detect), 24'h1);
        phase_ok = 1'b0;
        step(6);
        chk(24'(lock_detect), 24'h0);
    endtask
    task automatic t_pin_reset;
        reset_in_low = 1'b0;
        step(5);
        reset_in_low = 1'b1;
        step(5);
        chk({div_int, 5'h0, cp_enable, synth_pwr, ref_amp_en}, 24'h0);
    endtask
    initial begin
        #600000;
        errors++;
        close_out;
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        reset_in_low = 1'b1;
        lock_analog = 1'b0;
        phase_ok = 1'b0;
        reg_stable = 4'h5;
        step(2);
        rst = 1'b0;
        step(4);
        t_reset;
        t_enable;
        t_gen_reset;
        t_integer;
        t_fraction;
        t_lock;
        t_pin_reset;
        close_out;
    end
endmodule // tb_fns_synth_control
bind fns_synth_control fns_synth_checker fns_synth_checker_i (.ref_clk(ref_clk), .rst(rst),
    .reset_in_low(reset_in_low), .ser_cs_n(ser_cs_n), .ser_data_oe(ser_data_oe), .ref_amp_en(ref_amp_en),
    .ref_clk_gate(ref_clk_gate), .synth_pwr(synth_pwr), .if_synth_pwr(if_synth_pwr), .cp_enable(cp_enable),
    .fast_lock_output(fast_lock_output), .lock_detect(lock_detect), .div_int(div_int), .div_frac(div_frac),
    .div_load(div_load));
